// ===== design/rtcsp_pkg.sv
// Purpose: Constants for the serial slave port of the real-time-clock device.
// Assumes: Addresses are eight bits, the top bit being the direction bit.
package rtcsp_pkg;
	localparam int RTCSP_BYTE_W = 8;
	localparam int RTCSP_LOC_W = 7;
	localparam int RTCSP_DIR_BIT = 7;
	localparam logic [2:0] RTCSP_LAST_BIT = 3'h7;
	localparam logic [6:0] RTCSP_CLK_LAST = 7'h1F;
	localparam logic [6:0] RTCSP_CLK_FIRST = 7'h00;
	localparam logic [6:0] RTCSP_RAM_LAST = 7'h7F;
	localparam logic [6:0] RTCSP_RAM_FIRST = 7'h20;
	localparam logic [6:0] RTCSP_CTRL_LOC = 7'h0F;
	localparam logic [6:0] RTCSP_TRICKLE_LOC = 7'h11;
	localparam int RTCSP_LOCK_BIT = 6;
	localparam logic [7:0] RTCSP_TRICKLE_RST = 8'h00;
	localparam logic [3:0] RTCSP_CHARGER_KEY = 4'hA;
	localparam logic [1:0] RTCSP_DIODE_ONE = 2'h1;
	localparam logic [1:0] RTCSP_DIODE_TWO = 2'h2;
	localparam logic [1:0] RTCSP_RES_NONE = 2'h0;
	localparam int RTCSP_FIFO_DEPTH = 16;
	typedef enum logic [1:0] {
		RTCSP_ST_IDLE,
		RTCSP_ST_ADDR,
		RTCSP_ST_WRITE,
		RTCSP_ST_READ
	} rtcsp_state_t;
endpackage

// ===== design/rtcsp_fifo_if.sv
// Purpose: Carrier between the port logic and its write FIFO.
// Assumes: One clock domain on both sides.
// Notes: Valid and ready on both sides.
`timescale 1ns/1ps
interface rtcsp_fifo_if #(parameter int WIDTH = 15);
	logic in_valid;
	logic in_ready;
	logic [WIDTH-1:0] in_data;
	logic out_valid;
	logic out_ready;
	logic [WIDTH-1:0] out_data;
	modport fifo (input in_valid, in_data, out_ready, output in_ready, out_valid, out_data);
	modport user (output in_valid, in_data, out_ready, input in_ready, out_valid, out_data);
endinterface

// ===== design/rtcsp_fifo.sv
// Purpose: Synchronous FIFO for committed write bytes.
// Assumes: DEPTH is a power of two.
// Notes: Extra pointer bit gives honest full and empty.
`timescale 1ns/1ps
module rtcsp_fifo #(
	parameter int WIDTH = 15,
	parameter int DEPTH = 16
) (
	input wire logic core_clk,
	input wire logic sys_rst,
	rtcsp_fifo_if.fifo port
);
	localparam int AW = $clog2(DEPTH);
	logic [WIDTH-1:0] mem [DEPTH];
	logic [AW:0] wr_ptr_r;
	logic [AW:0] rd_ptr_r;
	wire full = (wr_ptr_r[AW] != rd_ptr_r[AW]) && (wr_ptr_r[AW-1:0] == rd_ptr_r[AW-1:0]);
	wire empty = (wr_ptr_r == rd_ptr_r);
	wire push = port.in_valid && !full;
	wire pop = port.out_ready && !empty;
	assign port.in_ready = !full;
	assign port.out_valid = !empty;
	assign port.out_data = mem[rd_ptr_r[AW-1:0]];
	always_ff @(posedge core_clk) begin
		if (push) begin
			mem[wr_ptr_r[AW-1:0]] <= port.in_data;
		end
	end
	always_ff @(posedge core_clk or posedge sys_rst) begin
		if (sys_rst) begin
			wr_ptr_r <= '0;
			rd_ptr_r <= '0;
		end else begin
			if (push) begin
				wr_ptr_r <= wr_ptr_r + 1'b1;
			end
			if (pop) begin
				rd_ptr_r <= rd_ptr_r + 1'b1;
			end
		end
	end
endmodule

// ===== design/rtcsp_port.sv
// Purpose: Serial slave port: SPI or three-wire, burst addressing, write gating.
// Assumes: Link clock well below core_clk; every pin is sampled through two flops.
// Notes: Register storage lives outside; reads via rd_*, writes leave through the FIFO.
`timescale 1ns/1ps
module rtcsp_port #(
	parameter logic LOCK_RST = 1'b1,
	parameter int FIFO_DEPTH = 16
) (
	input wire logic core_clk,
	input wire logic sys_rst,
	input wire logic interface_select_pin,
	input wire logic chip_enable,
	input wire logic shift_clk,
	input wire logic serial_in,
	output logic serial_out,
	output logic serial_out_oe,
	input wire logic primary_supply_low,
	input wire logic lithium_backup,
	output logic [rtcsp_pkg::RTCSP_BYTE_W-1:0] rd_addr,
	output logic rd_req,
	input wire logic [rtcsp_pkg::RTCSP_BYTE_W-1:0] rd_data,
	output logic wr_valid,
	input wire logic wr_ready,
	output logic [rtcsp_pkg::RTCSP_LOC_W-1:0] wr_addr,
	output logic [rtcsp_pkg::RTCSP_BYTE_W-1:0] wr_data,
	output logic wr_fifo_ready,
	output logic wr_overrun,
	output logic write_lock,
	output logic [1:0] resistor_select_field,
	output logic [3:0] charger_key_field,
	output logic [3:0] resistor_onehot,
	output logic charger_enable
);
	import rtcsp_pkg::*;

	localparam int FW = RTCSP_LOC_W + RTCSP_BYTE_W;
	localparam int NSYNC = 6;

	// Pin synchronisers; stage one feeds stage two only
	logic [NSYNC-1:0] meta_r;
	logic [NSYNC-1:0] sync_r;
	wire [NSYNC-1:0] pins_raw = {interface_select_pin, chip_enable, shift_clk, serial_in,
		primary_supply_low, lithium_backup};
	wire mode_s = sync_r[5];
	wire ce_s = sync_r[4];
	wire sclk_s = sync_r[3];
	wire sdi_s = sync_r[2];
	wire prim_low_s = sync_r[1];
	wire lith_s = sync_r[0];

	always_ff @(posedge core_clk or posedge sys_rst) begin
		if (sys_rst) begin
			meta_r <= '0;
			sync_r <= '0;
		end else begin
			meta_r <= pins_raw;
			sync_r <= meta_r;
		end
	end

	logic ce_d_r;
	logic sclk_d_r;
	logic spi_r;
	logic idle_r;
	rtcsp_state_t state_r;
	logic [2:0] bit_cnt_r;
	logic [7:0] shreg_r;
	logic [7:0] addr_r;
	logic [7:0] tx_r;
	logic tx_valid_r;
	logic rd_pend_r;
	logic rd_req_r;
	logic [7:0] rd_addr_r;
	logic so_r;
	logic oe_r;
	logic lock_r;
	logic [7:0] trickle_r;
	logic overrun_r;

	// Edge finding on the sampled link clock
	wire ce_rise = ce_s && !ce_d_r;
	wire sclk_rise = sclk_s && !sclk_d_r;
	wire sclk_fall = !sclk_s && sclk_d_r;
	// SPI strobes on the edge back to idle, shifts on the edge leaving it
	wire spi_strobe = idle_r ? sclk_rise : sclk_fall;
	wire spi_shift = idle_r ? sclk_fall : sclk_rise;
	wire strobe_edge = spi_r ? spi_strobe : sclk_rise;
	wire shift_edge = spi_r ? spi_shift : sclk_fall;
	wire in_xfer = ce_s && ce_d_r && (state_r != RTCSP_ST_IDLE);
	wire do_strobe = in_xfer && strobe_edge;
	wire do_shift = in_xfer && shift_edge;

	// Bit order per mode
	wire [7:0] msb_byte = {shreg_r[6:0], sdi_s};
	wire [7:0] lsb_byte = {sdi_s, shreg_r[7:1]};
	wire [7:0] in_byte = spi_r ? msb_byte : lsb_byte;
	wire byte_done = do_strobe && (bit_cnt_r == RTCSP_LAST_BIT);
	wire is_read_addr = !in_byte[RTCSP_DIR_BIT];

	// Auto increment with region wrap; top bit kept, so write wraps follow
	wire [6:0] loc = addr_r[6:0];
	wire [6:0] loc_plus = loc + 7'h01;
	wire [6:0] loc_next = (loc == RTCSP_CLK_LAST) ? RTCSP_CLK_FIRST :
		(loc == RTCSP_RAM_LAST) ? RTCSP_RAM_FIRST : loc_plus;
	wire [7:0] addr_next = {addr_r[7], loc_next};

	// Write gating
	wire supply_block = lith_s && prim_low_s;
	wire is_ctrl = (loc == RTCSP_CTRL_LOC);
	wire is_trickle = (loc == RTCSP_TRICKLE_LOC);
	wire wr_byte = byte_done && (state_r == RTCSP_ST_WRITE);
	wire lock_wr = wr_byte && !supply_block && is_ctrl;
	wire write_ok = wr_byte && !supply_block && !lock_r;
	wire trickle_wr = write_ok && is_trickle;

	rtcsp_fifo_if #(.WIDTH(FW)) fq ();

	rtcsp_fifo #(
		.WIDTH(FW),
		.DEPTH(FIFO_DEPTH)
	) u_fifo (
		.core_clk(core_clk),
		.sys_rst(sys_rst),
		.port(fq.fifo)
	);

	assign fq.in_valid = write_ok;
	assign fq.in_data = {loc, in_byte};
	assign fq.out_ready = wr_ready;
	assign wr_valid = fq.out_valid;
	assign wr_addr = fq.out_data[FW-1:RTCSP_BYTE_W];
	assign wr_data = fq.out_data[RTCSP_BYTE_W-1:0];
	assign wr_fifo_ready = fq.in_ready;

	// Read data source: internal copies override the outside bank
	wire [7:0] rd_loc_ctrl = {rd_data[7], lock_r, rd_data[5:0]};
	wire rd_is_trickle = (rd_addr_r[6:0] == RTCSP_TRICKLE_LOC);
	wire rd_is_ctrl = (rd_addr_r[6:0] == RTCSP_CTRL_LOC);
	wire [7:0] rd_value = rd_is_trickle ? trickle_r : (rd_is_ctrl ? rd_loc_ctrl : rd_data);
	wire [7:0] tx_shifted = spi_r ? {tx_r[6:0], 1'b0} : {1'b0, tx_r[7:1]};
	wire tx_bit = spi_r ? tx_r[7] : tx_r[0];

	always_ff @(posedge core_clk or posedge sys_rst) begin
		if (sys_rst) begin
			ce_d_r <= 1'b0;
			sclk_d_r <= 1'b0;
		end else begin
			ce_d_r <= ce_s;
			sclk_d_r <= sclk_s;
		end
	end

	// Transfer sequencer
	always_ff @(posedge core_clk or posedge sys_rst) begin
		if (sys_rst) begin
			state_r <= RTCSP_ST_IDLE;
			spi_r <= 1'b1;
			idle_r <= 1'b0;
			bit_cnt_r <= 3'h0;
			shreg_r <= 8'h00;
			addr_r <= 8'h00;
		end else if (!ce_s) begin
			state_r <= RTCSP_ST_IDLE;
			bit_cnt_r <= 3'h0;
		end else if (ce_rise) begin
			state_r <= RTCSP_ST_ADDR;
			spi_r <= mode_s;
			idle_r <= sclk_s;
			bit_cnt_r <= 3'h0;
		end else if (do_strobe) begin
			shreg_r <= in_byte;
			bit_cnt_r <= bit_cnt_r + 3'h1;
			if (byte_done) begin
				case (state_r)
					RTCSP_ST_ADDR: begin
						addr_r <= in_byte;
						state_r <= is_read_addr ? RTCSP_ST_READ : RTCSP_ST_WRITE;
					end
					RTCSP_ST_WRITE: begin
						addr_r <= addr_next;
					end
					RTCSP_ST_READ: begin
						addr_r <= addr_next;
					end
					default: begin
						state_r <= RTCSP_ST_IDLE;
					end
				endcase
			end
		end
	end

	// Read fetch: request at each byte boundary, load two cycles later
	always_ff @(posedge core_clk or posedge sys_rst) begin
		if (sys_rst) begin
			rd_req_r <= 1'b0;
			rd_addr_r <= 8'h00;
			rd_pend_r <= 1'b0;
		end else begin
			rd_req_r <= 1'b0;
			rd_pend_r <= rd_req_r && ce_s;
			if (byte_done && state_r == RTCSP_ST_ADDR && is_read_addr) begin
				rd_req_r <= 1'b1;
				rd_addr_r <= in_byte;
			end else if (byte_done && state_r == RTCSP_ST_READ) begin
				rd_req_r <= 1'b1;
				rd_addr_r <= addr_next;
			end
		end
	end

	// Output shifter; enable rises only once a whole byte is loaded
	always_ff @(posedge core_clk or posedge sys_rst) begin
		if (sys_rst) begin
			tx_r <= 8'h00;
			tx_valid_r <= 1'b0;
			so_r <= 1'b0;
			oe_r <= 1'b0;
		end else if (!ce_s || state_r != RTCSP_ST_READ) begin
			tx_valid_r <= 1'b0;
			oe_r <= 1'b0;
		end else if (rd_pend_r) begin
			tx_r <= rd_value;
			tx_valid_r <= 1'b1;
		end else if (do_shift && tx_valid_r) begin
			so_r <= tx_bit;
			tx_r <= tx_shifted;
			oe_r <= 1'b1;
		end
	end

	// Lock bit, charger register, overrun flag
	always_ff @(posedge core_clk or posedge sys_rst) begin
		if (sys_rst) begin
			lock_r <= LOCK_RST;
			trickle_r <= RTCSP_TRICKLE_RST;
			overrun_r <= 1'b0;
		end else begin
			if (lock_wr) begin
				lock_r <= in_byte[RTCSP_LOCK_BIT];
			end
			if (trickle_wr) begin
				trickle_r <= in_byte;
			end
			// Master cannot be stalled, so a byte meeting a full FIFO is lost and flagged
			if (write_ok && !fq.in_ready) begin
				overrun_r <= 1'b1;
			end else if (ce_rise) begin
				overrun_r <= 1'b0;
			end
		end
	end

	// Charger decode
	wire [1:0] diode_sel = trickle_r[3:2];
	wire diode_ok = (diode_sel == RTCSP_DIODE_ONE) || (diode_sel == RTCSP_DIODE_TWO);
	wire key_ok = (trickle_r[7:4] == RTCSP_CHARGER_KEY);
	wire res_ok = (trickle_r[1:0] != RTCSP_RES_NONE);

	genvar gi;
	generate
		for (gi = 0; gi < 4; gi++) begin : g_res
			assign resistor_onehot[gi] = (trickle_r[1:0] == 2'(gi));
		end
	endgenerate

	assign charger_enable = key_ok && diode_ok && res_ok;
	assign resistor_select_field = trickle_r[1:0];
	assign charger_key_field = trickle_r[7:4];
	assign serial_out = so_r;
	assign serial_out_oe = oe_r && ce_s;
	assign rd_req = rd_req_r;
	assign rd_addr = rd_addr_r;
	assign wr_overrun = overrun_r;
	assign write_lock = lock_r;
endmodule

// ===== testbench/rtcsp_port_assertions.sv
// Purpose: Port checks for rtcsp_port.
// Assumes: One core_clk domain.
// Notes: Bound to every rtcsp_port.
`timescale 1ns/1ps
module rtcsp_port_assertions (
	input logic core_clk,
	input logic sys_rst,
	input logic chip_enable,
	input logic serial_out_oe,
	input logic [7:0] rd_addr,
	input logic rd_req,
	input logic wr_valid,
	input logic [6:0] wr_addr,
	input logic write_lock,
	input logic [1:0] resistor_select_field,
	input logic [3:0] charger_key_field,
	input logic [3:0] resistor_onehot,
	input logic charger_enable
);
	import rtcsp_pkg::*;
	logic seen_r;
	logic [7:0] last_r;
	logic [7:0] addr_nxt;
	assign addr_nxt[7] = last_r[7];
	assign addr_nxt[6:0] = last_r[6:0] == RTCSP_CLK_LAST ? RTCSP_CLK_FIRST :
		last_r[6:0] == RTCSP_RAM_LAST ? RTCSP_RAM_FIRST : last_r[6:0] + 7'h01;
	// Cleared on raw enable low, so a new frame never inherits a burst
	always_ff @(posedge core_clk or posedge sys_rst) begin
		if (sys_rst)
			seen_r <= 1'b0;
		else
			seen_r <= chip_enable & (seen_r | rd_req);
	end
	always_ff @(posedge core_clk) begin
		if (rd_req)
			last_r <= rd_addr;
	end
	default clocking @(posedge core_clk); endclocking
	default disable iff (sys_rst);
	oe_off_ce_a: assert property (!chip_enable [*3] |-> !serial_out_oe)
		else $error("output driven while disabled");
	rdreq_pulse_a: assert property (rd_req |=> !rd_req)
		else $error("read request too long");
	rdaddr_hold_a: assert property ($changed(rd_addr) |-> rd_req)
		else $error("read address moved alone");
	burst_wrap_a: assert property (rd_req && seen_r |-> rd_addr == addr_nxt)
		else $error("bad burst address");
	oe_read_a: assert property ($rose(serial_out_oe) |-> seen_r)
		else $error("output driven before read byte");
	res_onehot_a: assert property (resistor_onehot == 4'h1 << resistor_select_field)
		else $error("bad resistor decode");
	charger_en_a: assert property (charger_enable |->
		charger_key_field == RTCSP_CHARGER_KEY && resistor_select_field != RTCSP_RES_NONE)
		else $error("charger on wrongly");
	lock_block_a: assert property ($rose(wr_valid) |->
		!$past(write_lock, 2) || wr_addr == RTCSP_CTRL_LOC)
		else $error("write passed lock");
endmodule
bind rtcsp_port rtcsp_port_assertions chk_i (.core_clk, .sys_rst, .chip_enable,
	.serial_out_oe, .rd_addr, .rd_req, .wr_valid, .wr_addr, .write_lock,
	.resistor_select_field, .charger_key_field, .resistor_onehot, .charger_enable);

// ===== testbench/rtcsp_master.sv
// Purpose: Serial bus master model.
// Assumes: 400 ns link period.
// Notes: Samples 20 ns after the latch edge.
`timescale 1ns/1ps
module rtcsp_master (
	output logic interface_select_pin,
	output logic chip_enable,
	output logic shift_clk,
	output logic serial_in,
	input logic serial_out,
	input logic serial_out_oe
);
	logic dout, drv, idle, line;
	// Released line shows the inverse of the last bit
	assign serial_in = !interface_select_pin && serial_out_oe ? serial_out : drv ? dout : ~dout;
	assign line = interface_select_pin ? serial_out : serial_in;
	initial begin
		interface_select_pin = 1'b1;
		{chip_enable, shift_clk, dout, drv, idle} = 5'h00;
	end
	task start(input logic spi, input logic idl);
		#50 interface_select_pin = spi;
		idle = idl;
		shift_clk = idl;
		#200 chip_enable = 1'b1;
		#300;
	endtask
	task stop();
		#100 chip_enable = 1'b0;
		#300;
	endtask
	task xfer(input logic [7:0] tx, input int n, input logic d, output logic [7:0] rx);
		int i;
		int k;
		logic lf;
		lf = !interface_select_pin && !idle;
		rx = 8'h00;
		for (i = 0; i < n; i++) begin
			k = interface_select_pin ? 7 - i : i;
			drv = d;
			dout = tx[k];
			#100 shift_clk = ~idle;
			#20 if (lf) rx[k] = line;
			#180 shift_clk = idle;
			#20 if (!lf) rx[k] = line;
			#80;
		end
		drv = 1'b0;
	endtask
endmodule

// ===== testbench/rtcsp_port_tb.sv
// Purpose: Self-checking bench for rtcsp_port.
// Assumes: Consumer pops writes; read data is location XOR A5h.
// Notes: Expected writes queue up in exp_q.
`timescale 1ns/1ps
module rtcsp_port_tb;
	import rtcsp_pkg::*;
	logic core_clk, sys_rst, interface_select_pin, chip_enable, shift_clk, serial_in;
	logic serial_out, serial_out_oe, primary_supply_low, lithium_backup, rd_req, wr_valid;
	logic wr_ready, wr_fifo_ready, wr_overrun, write_lock, charger_enable, oe_seen;
	logic [7:0] rd_addr, rd_data, wr_data;
	logic [6:0] wr_addr;
	logic [1:0] resistor_select_field;
	logic [3:0] charger_key_field, resistor_onehot;
	logic [14:0] got[$], exp_q[$];
	int miscompares, n_checks, cyc;
	assign rd_data = rd_addr ^ 8'hA5;
	rtcsp_port dut (.core_clk, .sys_rst, .interface_select_pin, .chip_enable, .shift_clk,
		.serial_in, .serial_out, .serial_out_oe, .primary_supply_low, .lithium_backup,
		.rd_addr, .rd_req, .rd_data, .wr_valid, .wr_ready, .wr_addr, .wr_data,
		.wr_fifo_ready, .wr_overrun, .write_lock, .resistor_select_field,
		.charger_key_field, .resistor_onehot, .charger_enable);
	rtcsp_master m (.interface_select_pin, .chip_enable, .shift_clk, .serial_in,
		.serial_out, .serial_out_oe);
	initial begin
		core_clk = 1'b0;
		forever #25 core_clk = ~core_clk;
	end
	always @(posedge core_clk) begin
		cyc++;
		if (serial_out_oe)
			oe_seen = 1'b1;
		if (wr_valid === 1'b1 && wr_ready)
			got.push_back({wr_addr, wr_data});
		if (cyc == 20000) begin
			miscompares++;
			finish_test();
		end
	end
	task chk(input logic [14:0] g, input logic [14:0] e);
		n_checks++;
		if (g !== e) begin
			miscompares++;
			$display("CHECK FAILED %0t got %h exp %h", $time, g, e);
		end
	endtask
	task finish_test();
		if (miscompares == 0 && n_checks > 0)
			$display("Finished cleanly");
		else
			$display("Finished with errors");
		$finish;
	endtask
	function automatic logic [7:0] step(input logic [7:0] a);
		step = {a[7], a[6:0] == 7'h1F ? 7'h00 : a[6:0] == 7'h7F ? 7'h20 : a[6:0] + 7'h01};
	endfunction
	task xact(input logic spi, input logic idl, input logic [7:0] a, input int n,
		input logic [7:0] d, input logic ok);
		logic [7:0] rx;
		logic [7:0] cur;
		int i;
		cur = a;
		m.start(spi, idl);
		m.xfer(a, 8, 1'b1, rx);
		for (i = 0; i < n; i++) begin
			m.xfer(d + i[7:0], 8, a[7], rx);
			if (!a[7])
				chk(15'(rx), 15'(cur ^ 8'hA5));
			else if (ok)
				exp_q.push_back({cur[6:0], d + i[7:0]});
			cur = step(cur);
		end
		m.stop();
		chk(15'(serial_out_oe), 15'h0);
	endtask
	// Waits long enough for the consumer to empty the queue
	task drain();
		repeat (20) @(negedge core_clk);
		chk(15'(got.size()), 15'(exp_q.size()));
		while (got.size() > 0 && exp_q.size() > 0)
			chk(got.pop_front(), exp_q.pop_front());
		got.delete();
		exp_q.delete();
	endtask
	task t_read();
		int c;
		logic [7:0] s [4];
		s = '{8'h1E, 8'h7F, 8'h1F, 8'h7E};
		for (c = 0; c < 4; c++)
			xact(c[1], c[0], s[c], 3, 8'h00, 1'b0);
		drain();
	endtask
	task t_write();
		logic [7:0] rx;
		oe_seen = 1'b0;
		xact(1'b1, 1'b1, 8'hFE, 3, 8'h10, 1'b1);
		xact(1'b0, 1'b0, 8'h9E, 3, 8'h20, 1'b1);
		m.start(1'b1, 1'b0);
		m.xfer(8'hA4, 8, 1'b1, rx);
		m.xfer(8'h55, 5, 1'b1, rx);
		m.stop();
		drain();
		chk(15'(oe_seen), 15'h0);
	endtask
	// Charger reads come wholly from the internal copy; control reads take only the lock bit from it, the rest from the outside bank
	task t_shadow_rd(input logic [7:0] a, input logic [7:0] e);
		logic [7:0] rx;
		m.start(1'b1, 1'b0);
		m.xfer(a, 8, 1'b1, rx);
		m.xfer(8'h00, 8, 1'b0, rx);
		m.stop();
		chk(15'(rx), 15'(e));
	endtask
	task t_charger();
		int rs;
		for (rs = 0; rs < 4; rs++) begin
			xact(1'b1, 1'b0, 8'h91, 1, {4'hA, 2'h1, rs[1:0]}, 1'b1);
			drain();
			chk(15'({resistor_onehot, charger_enable, charger_key_field, resistor_select_field}),
				15'({4'h1 << rs[1:0], rs != 0, 4'hA, rs[1:0]}));
			chk(15'(wr_overrun), 15'h0);
		end
		t_shadow_rd(8'h11, 8'hA7);
		xact(1'b1, 1'b0, 8'h91, 1, 8'h55, 1'b1);
		drain();
		chk(15'(charger_enable), 15'h0);
	endtask
	initial begin
		{sys_rst, wr_ready} = 2'h3;
		{primary_supply_low, lithium_backup, oe_seen} = 3'h0;
		repeat (5) @(negedge core_clk);
		sys_rst = 1'b0;
		chk(15'({serial_out_oe, rd_req, wr_valid, wr_fifo_ready, wr_overrun, write_lock,
			charger_enable, resistor_onehot}), 15'h0A1);
		t_shadow_rd(8'h0F, 8'hEA);
		xact(1'b1, 1'b0, 8'h80, 1, 8'h33, 1'b0);
		// Unlock only flips the lock bit; the byte itself stays blocked
		xact(1'b1, 1'b0, 8'h8F, 1, 8'h00, 1'b0);
		drain();
		chk(15'(write_lock), 15'h0);
		t_read();
		t_write();
		wr_ready = 1'b0;
		xact(1'b1, 1'b0, 8'h80, 17, 8'h00, 1'b1);
		void'(exp_q.pop_back());
		chk(15'({wr_fifo_ready, wr_overrun}), 15'h1);
		@(negedge core_clk) wr_ready = 1'b1;
		drain();
		t_charger();
		{primary_supply_low, lithium_backup} = 2'h3;
		xact(1'b1, 1'b0, 8'h85, 1, 8'h77, 1'b0);
		xact(1'b1, 1'b0, 8'h8F, 1, 8'h40, 1'b0);
		drain();
		chk(15'(write_lock), 15'h0);
		@(negedge core_clk) lithium_backup = 1'b0;
		xact(1'b1, 1'b0, 8'h85, 1, 8'h77, 1'b1);
		drain();
		finish_test();
	end
endmodule
